// >>> bench/epd_fetch_model.sv
// Purpose: Fetch unit stand-in offering one whole packet at a time
// Assumes: Packet taken at an edge with valid and ready both high
// Notes:   Idle data is inverted so stale words never pass for fresh
`timescale 1ns/1ps
`default_nettype none
module epd_fetch_model (
   input  wire logic         clock,
   input  wire logic         go,
   input  wire logic [511:0] pkt,
   input  wire logic         fp_ready,
   output var  logic         fp_valid,
   output var  logic [511:0] fp_data
);
   initial fp_valid = 1'b0;
   initial fp_data = '0;
   always @(posedge clock) begin
      if (fp_valid && fp_ready) begin
         fp_valid <= 1'b0;
         fp_data  <= ~fp_data;
      end else if (go) begin
         fp_valid <= 1'b1;
         fp_data  <= pkt;
      end
   end
endmodule : epd_fetch_model
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench for the execute packet dispatch stage
// Assumes: Bus slave answers with zero wait states
// Notes:   Unitless filler words issue empty groups
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic         clock = 0, nrst = 0, hsel = 0, hwrite = 0, go = 0;
   logic [1:0]   htrans = 0;
   logic [31:0]  haddr = 0, hwdata = 0, r, e, x, s = 32'h0657, i0, hrdata, y;
   logic [511:0] pkt = 0, fd;
   logic [191:0] pv = 0, pn;
   logic [63:0]  wi;
   logic [5:0]   pw = 0;
   logic         fv, fr, hro, i0v, u0, ex, wv;
   logic [12:0]  uv, ue;
   logic [3:0]   sel, i0u;
   int           failures = 0, compares = 0, n, k, g[$], ns = 0;
   always #5 clock = ~clock;
   always_comb u0 = uv[0];
   epd_dispatch epd_dispatch_i (.clock(clock), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hro), .hreadyout(hro), .hrdata(hrdata),
      .hresp(), .fp_valid(fv), .fp_data(fd), .fp_ready(fr),
      .pred_value(pv), .pred_wr(pw), .unit_valid(uv), .unit_insn(),
      .unit_exec(ue), .imm0_valid(i0v), .imm0(i0), .imm0_unit(i0u),
      .imm1_valid(), .imm1(), .imm1_unit(), .wide_imm_valid(wv),
      .wide_imm(wi), .wb_exception());
   epd_fetch_model epd_fetch_model_i (.clock(clock), .go(go), .pkt(pkt),
      .fp_ready(fr), .fp_valid(fv), .fp_data(fd));
   function automatic logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : rnd
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [63:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   // Bounded wait; samples at the edge so a one-cycle pulse is seen
   task automatic await(ref logic y);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (y !== 1'b1 && n < 200);
      if (n >= 200) begin
         failures++;
         conclude();
      end
   endtask : await
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      await(hro);
      htrans <= 2'h0;
      hwdata <= d;
      await(hro);
      // Select stays up between calls; IDLE htrans keeps the slave quiet
      r = hrdata;
   endtask : bus
   task automatic send();
      await(fr);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
   endtask : send
   initial begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      bus(0, 32'h0, 0);
      chk(r, 1, "ctrl reset");
      bus(1, 32'h40, 32'hffffffff);
      bus(0, 32'h40, 0);
      chk(r, 0, "unmapped");
      // Partially serial packet: groups of 1, 1, 7, 4 and 3 words
      g = {1, 1, 7, 4, 3};
      k = 0;
      foreach (g[j]) for (int i = 0; i < g[j]; i++) begin
         pkt[32*k +: 32] = {20'h0, 4'(i), 7'h0, 1'(i < g[j] - 1)};
         k++;
      end
      send();
      foreach (g[j]) begin
         await(u0);
         if (j > 0) chk(n, 1, "group late");
         chk($countones(uv), g[j], "group size");
      end
      $display("test serial groups done");
      // Every selector code through condition extension zero on logic a;
      // all sources count as just written, so predicated vector groups stall
      pw <= 6'h3f;
      for (int c = 0; c < 16; c++) begin
         e = rnd();
         x = rnd();
         y = rnd();
         for (int q = 0; q < 6; q++) pn[32*q +: 32] = rnd() & {32{x[q]}};
         pv <= pn;
         sel = 4'(c);
         // Payload bit 1 set and bit 28 clear so no word aliases an id
         pkt = {16{32'h00000d00}};
         pkt[31:0] = {sel, 21'h0, 7'h1d};
         pkt[63:32] = {5'h1e, e[26:2], 2'b11};
         pkt[95:64] = {x[31:29], 1'b0, x[27:18], 3'b101, 7'h0, 3'h2, 5'h0};
         // At most two constant extensions in one execute packet
         if (c % 2 == 0) pkt[511:480] = {5'h1f, 27'h0};
         else pkt[191:96] = {4'h0, x[27:18], 6'h0, 4'h7, 3'h3, 5'h0,
            5'h1f, ~y[26:2], 2'b11, 5'h1e, y[26:2], 2'b11};
         if (sel == 4'h0) ex = 1'b1;
         else if (sel == 4'h1 || sel[3:1] == 3'h7) ex = 1'b0;
         else begin
            ex = (pn[32*(sel[3:1]-1) +: 32] != 0) ^ sel[0];
            ns++;
         end
         send();
         await(u0);
         chk(ue[0], ex, "predicate");
         chk(i0v, 1, "imm valid");
         chk(i0, {e[26:2], 2'b11, x[22:18]}, "imm value");
         chk(i0u, epd_pkg::U_L1, "imm unit");
         chk($countones(uv), 1, "ext dispatched");
         if (c % 2 == 1) begin
            await(wv);
            chk(n, 1, "wide group late");
            chk(wi, {~y[26:2], 2'b11, y[26:2], 2'b11, x[27:18]}, "wide");
         end
      end
      $display("test predication done");
      await(fr);
      bus(0, 32'h4, 0);
      chk(r, 32'h1 << epd_pkg::ST_RSVSEL, "status");
      bus(1, 32'h4, 32'hff);
      bus(0, 32'h4, 0);
      chk(r, 0, "status clear");
      // Serial groups, then 14 groups on even and 12 on odd packets
      bus(0, 32'h8, 0);
      chk(r, 5 + 8 * (14 + 12), "packet count");
      bus(0, 32'hc, 0);
      chk(r, ns, "stall count");
      $display("test registers done");
      conclude();
   end
endmodule : tb
`default_nettype wire

// >>> verilog/epd_dispatch.sv
// Purpose: Split fetch packets into execute packets, predicate and dispatch
// Assumes: Inputs synchronous to clock; AHB-Lite slave, zero wait states
// Notes:   One execute packet per cycle; unit_valid pulses for one cycle, unit_insn and unit_exec hold
// Behaviour
// - Bit 0 set chains the next word; clear ends the execute packet.
// - Fetch packets are sixteen aligned words; execute packets hold up to sixteen.
// - A fetch packet holds at most two constant and two condition extensions; the code only flags a repeated extension within one execute packet.
// - After a packet ends, the next group issues together on the following cycle.
// - Only control and move instructions carry an embedded selector; others unconditional.
// - Two distinct condition extensions give selectors for their own packet.
// - An extension selector overrides the embedded selector for its unit.
// - Selector 0000 unconditional, 0001 and 111x reserved, others pick sources 0-5.
// - Normal predicate runs on nonzero source, inverted one on zero source.
// - Condition extension 0 has id 0011101 and serves logic, shift, memory units.
// - Condition extension 1 has id 1011101 and serves multiply, control, predicate units.
// - A vector predicate used right after being written costs one stall cycle.
// - At most two constant extensions serve each execute packet.
// - Constant extension 0 serves its fixed set of units and fields.
// - Constant extension 1 serves the complementary set of units and fields.
// - One extension per instruction except wide move and store, which use both.
// - Move-constant value is extension 0 bits 26..0 over the 5-bit embedded field.
// - Wide move is extension 1, extension 0, then the 10-bit embedded field.
// - Branch instructions sit last in their execute packet.
// - Predicate-destination instructions go only to side B units.
// - Two results from one unit in one cycle raise an exception.
// - Multiply units still retire one result per cycle despite two ports.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module epd_dispatch #(
   parameter int NSLOT = 16
) (
   input  wire logic                   clock,
   input  wire logic                   nrst,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic [31:0]                 hrdata,
   output logic                        hresp,
   input  wire logic                   fp_valid,
   input  wire logic [NSLOT*32-1:0]    fp_data,
   output logic                        fp_ready,
   input  wire logic [6*32-1:0]        pred_value,
   input  wire logic [5:0]             pred_wr,
   output logic [12:0]                 unit_valid,
   output logic [13*32-1:0]            unit_insn,
   output logic [12:0]                 unit_exec,
   output logic                        imm0_valid,
   output logic [31:0]                 imm0,
   output logic [3:0]                  imm0_unit,
   output logic                        imm1_valid,
   output logic [31:0]                 imm1,
   output logic [3:0]                  imm1_unit,
   output logic                        wide_imm_valid,
   output logic [63:0]                 wide_imm,
   output logic                        wb_exception
);
   localparam int W   = epd_pkg::WORD_W;
   localparam int NU  = epd_pkg::NUNIT;
   localparam int LN  = epd_pkg::LAT_N;
   localparam int PW  = epd_pkg::PAY_W;

   if (NSLOT < 1 || NSLOT > epd_pkg::SLOTS) begin : g_bad_nslot
      $error("NSLOT must lie between 1 and 16");
   end

   // Selector decode, shared by checking and evaluation
   function automatic logic sel_rsv(input logic [3:0] s);
      return s == epd_pkg::SEL_RSV || s[3:1] == epd_pkg::SEL_TOP;
   endfunction : sel_rsv

   function automatic logic pred_pass(input logic [3:0] s,
                                      input logic [6*32-1:0] pv);
      logic nz;
      nz = 1'b0;
      if (s == epd_pkg::SEL_UNCOND) return 1'b1;
      if (sel_rsv(s)) return 1'b0;
      nz = |pv[(int'(s[3:1]) - 1) * W +: W];
      return s[0] ? !nz : nz;
   endfunction : pred_pass

   // Returns {covered, slot, nibble position}
   function automatic logic [4:0] cond_map(input logic [3:0] u);
      unique case (u)
         epd_pkg::U_L1: return 5'h10;
         epd_pkg::U_L2: return 5'h11;
         epd_pkg::U_S1: return 5'h12;
         epd_pkg::U_S2: return 5'h13;
         epd_pkg::U_D1: return 5'h14;
         epd_pkg::U_D2: return 5'h15;
         epd_pkg::U_M1: return 5'h18;
         epd_pkg::U_M2: return 5'h19;
         epd_pkg::U_C:  return 5'h1a;
         epd_pkg::U_P:  return 5'h1b;
         epd_pkg::U_N1: return 5'h1c;
         epd_pkg::U_N2: return 5'h1d;
         default:       return 5'h00;
      endcase
   endfunction : cond_map

   // Returns {served, slot}
   function automatic logic [1:0] const_map(input logic [3:0] u,
                                            input logic sdata);
      unique case (u)
         epd_pkg::U_L1, epd_pkg::U_S2, epd_pkg::U_M2,
         epd_pkg::U_N2, epd_pkg::U_B, epd_pkg::U_C: return 2'h2;
         epd_pkg::U_L2, epd_pkg::U_S1, epd_pkg::U_M1,
         epd_pkg::U_N1: return 2'h3;
         epd_pkg::U_D1: return sdata ? 2'h2 : 2'h3;
         epd_pkg::U_D2: return sdata ? 2'h3 : 2'h2;
         default:       return 2'h0;
      endcase
   endfunction : const_map

   logic [NSLOT*32-1:0]  fp_q;
   logic                 have_q;
   logic [3:0]           cursor_q;
   logic                 fp_ready_q;
   logic                 stall_done_q;
   logic [5:0]           pwr_q;
   logic [NU*LN-1:0]     pend_q;
   logic                 ctrl_en_q;
   logic [epd_pkg::ST_W-1:0] status_q;
   logic [31:0]          pkts_q;
   logic [31:0]          stalls_q;
   logic                 wr_pend_q;
   logic [7:0]           wa_q;
   logic [31:0]          hrdata_q;
   logic                 hreadyout_q;
   logic [12:0]          unit_valid_q;
   logic [13*32-1:0]     unit_insn_q;
   logic [12:0]          unit_exec_q;
   logic                 imm0_valid_q;
   logic [31:0]          imm0_q;
   logic [3:0]           imm0_unit_q;
   logic                 imm1_valid_q;
   logic [31:0]          imm1_q;
   logic [3:0]           imm1_unit_q;
   logic                 wide_v_q;
   logic [63:0]          wide_q;
   logic                 wb_exc_q;

   // Decode results for the packet at the cursor
   logic [NSLOT-1:0]     mem_d;
   logic                 done_fp;
   logic [3:0]           last_idx;
   logic [3:0]           nxt_cur;
   logic [31:0]          x0_d, x1_d, c0_d, c1_d, w;
   logic [2:0]           nx0, nx1, nc0, nc1;
   logic [4:0]           n_norm;
   logic [12:0]          u_v_d, u_x_d;
   logic [13*32-1:0]     u_i_d;
   logic [NU*LN-1:0]     new_wb;
   logic                 need_stall, wb_conf, rsv_d, movk_d;
   logic                 use0, use1, wide_v_d;
   logic                 i0_v, i1_v;
   logic [31:0]          i0_d, i1_d;
   logic [3:0]           i0_u, i1_u, u, sel;
   logic [4:0]           cm;
   logic [1:0]           km;
   logic [2:0]           cls;
   logic [4:0]           movk_emb_d;
   logic [63:0]          wide_d;
   logic [epd_pkg::ST_W-1:0] err_d;
   logic                 ended, fire, stall;

   always_comb begin
      mem_d = '0; ended = 1'b0; last_idx = 4'h0; w = '0;
      x0_d = '0; x1_d = '0; c0_d = '0; c1_d = '0;
      nx0 = '0; nx1 = '0; nc0 = '0; nc1 = '0;
      for (int i = 0; i < NSLOT; i++) begin
         w = fp_q[i*W +: W];
         if (have_q && i >= int'(cursor_q) && !ended) begin
            mem_d[i] = 1'b1;
            // Last word of the fetch packet always closes the group
            if (!w[epd_pkg::PBIT] || i == NSLOT - 1) begin
               ended = 1'b1;
               last_idx = 4'(i);
            end
            if (w[6:0] == epd_pkg::COND0_ID) begin
               nc0 = nc0 + 3'h1; c0_d = w;
            end else if (w[6:0] == epd_pkg::COND1_ID) begin
               nc1 = nc1 + 3'h1; c1_d = w;
            end else if (w[31:epd_pkg::XID_LO] == epd_pkg::CONST0_ID) begin
               nx0 = nx0 + 3'h1; x0_d = w;
            end else if (w[31:epd_pkg::XID_LO] == epd_pkg::CONST1_ID) begin
               nx1 = nx1 + 3'h1; x1_d = w;
            end
         end
      end
      done_fp = int'(last_idx) == NSLOT - 1;
      nxt_cur = last_idx + 4'h1;
      err_d = '0;
      err_d[epd_pkg::ST_EXTCNT] = nc0 > 3'h1 || nc1 > 3'h1 ||
                                  nx0 > 3'h1 || nx1 > 3'h1;
      u_v_d = '0; u_x_d = '0; u_i_d = '0; new_wb = '0; n_norm = '0;
      need_stall = 1'b0; rsv_d = 1'b0; movk_d = 1'b0; movk_emb_d = '0;
      use0 = 1'b0; use1 = 1'b0; wide_v_d = 1'b0; wide_d = '0;
      i0_v = 1'b0; i1_v = 1'b0; i0_d = '0; i1_d = '0; i0_u = '0; i1_u = '0;
      u = '0; sel = '0; cm = '0; km = '0; cls = '0;
      for (int i = 0; i < NSLOT; i++) begin
         w = fp_q[i*W +: W];
         if (mem_d[i] && w[6:0] != epd_pkg::COND0_ID &&
             w[6:0] != epd_pkg::COND1_ID &&
             w[31:epd_pkg::XID_LO] != epd_pkg::CONST0_ID &&
             w[31:epd_pkg::XID_LO] != epd_pkg::CONST1_ID) begin
            n_norm = n_norm + 5'h1;
            u = w[epd_pkg::UNIT_LO +: 4];
            cls = w[epd_pkg::CLS_LO +: 3];
            cm = cond_map(u);
            // Embedded selector only on control and move classes
            sel = (cls == epd_pkg::CLS_BRANCH || cls == epd_pkg::CLS_MOVK ||
                   cls == epd_pkg::CLS_MOVW || cls == epd_pkg::CLS_CTLMOV)
                  ? w[epd_pkg::SEL_LO +: 4] : epd_pkg::SEL_UNCOND;
            if (cm[4] && !cm[3] && nc0 != 3'h0)
               sel = c0_d[31 - 4*int'(cm[2:0]) -: 4];
            else if (cm[4] && cm[3] && nc1 != 3'h0)
               sel = c1_d[31 - 4*int'(cm[2:0]) -: 4];
            if (sel_rsv(sel)) begin
               rsv_d = 1'b1;
            end
            if (w[epd_pkg::VEC_BIT] && sel != epd_pkg::SEL_UNCOND &&
                !sel_rsv(sel) && !stall_done_q &&
                pwr_q[int'(sel[3:1]) - 1]) begin
               need_stall = 1'b1;
            end
            if ((u == epd_pkg::U_B || cls == epd_pkg::CLS_BRANCH) &&
                w[epd_pkg::PBIT] && i != NSLOT - 1) begin
               err_d[epd_pkg::ST_BRLAST] = 1'b1;
            end
            if (w[epd_pkg::PDEST_BIT] && !u[0] && u < epd_pkg::U_C) begin
               err_d[epd_pkg::ST_PDEST] = 1'b1;
            end
            if (int'(u) < NU) begin
               if (u_v_d[u]) err_d[epd_pkg::ST_UNIT] = 1'b1;
               u_v_d[u] = 1'b1;
               u_i_d[int'(u)*W +: W] = w;
               u_x_d[u] = pred_pass(sel, pred_value);
               new_wb[int'(u)*LN + int'(w[epd_pkg::LAT_LO +: 2])] = 1'b1;
            end
            if (cls == epd_pkg::CLS_MOVW || cls == epd_pkg::CLS_STW) begin
               if (use0 || use1 || nx0 == 3'h0 || nx1 == 3'h0)
                  err_d[epd_pkg::ST_EXTUSE] = 1'b1;
               use0 = 1'b1; use1 = 1'b1; wide_v_d = 1'b1;
               wide_d = {x1_d[PW-1:0], x0_d[PW-1:0],
                         w[epd_pkg::EMB_LO +: 10]};
            end else if (cls == epd_pkg::CLS_MOVK ||
                         w[epd_pkg::USEX_BIT]) begin
               km = (cls == epd_pkg::CLS_MOVK) ? 2'h2
                    : const_map(u, w[epd_pkg::SDATA_BIT]);
               movk_d = movk_d | (cls == epd_pkg::CLS_MOVK);
               movk_emb_d = w[epd_pkg::EMB_LO +: 5];
               if (!km[1] || (!km[0] && (use0 || nx0 == 3'h0)) ||
                   (km[0] && (use1 || nx1 == 3'h0)))
                  err_d[epd_pkg::ST_EXTUSE] = 1'b1;
               if (!km[0]) begin
                  use0 = 1'b1; i0_v = 1'b1; i0_u = u;
                  i0_d = {x0_d[PW-1:0], w[epd_pkg::EMB_LO +: 5]};
               end else begin
                  use1 = 1'b1; i1_v = 1'b1; i1_u = u;
                  i1_d = {x1_d[PW-1:0], w[epd_pkg::EMB_LO +: 5]};
               end
            end
         end
      end
      wb_conf = 1'b0;
      for (int k = 0; k < NU; k++) begin
         // Covers multiply units too: two ports, still one result per cycle
         if (|((pend_q[k*LN +: LN] >> 1) & new_wb[k*LN +: LN]))
            wb_conf = 1'b1;
      end
      err_d[epd_pkg::ST_RSVSEL] = rsv_d;
      err_d[epd_pkg::ST_WB] = wb_conf;
      stall = have_q && ctrl_en_q && need_stall;
      fire = have_q && ctrl_en_q && !need_stall;
   end

   // Packet sequencing
   always_ff @(posedge clock) begin
      if (!nrst) begin
         fp_q <= '0;
         have_q <= 1'b0;
         cursor_q <= 4'h0;
         fp_ready_q <= 1'b1;
      end else if (fp_valid && fp_ready_q) begin
         fp_q <= fp_data;
         have_q <= 1'b1;
         cursor_q <= 4'h0;
         fp_ready_q <= 1'b0;
      end else if (fire) begin
         if (done_fp) begin
            have_q <= 1'b0;
            fp_ready_q <= 1'b1;
         end else begin
            cursor_q <= nxt_cur;
         end
      end
   end

   // Predicate hazard and writeback tracking
   always_ff @(posedge clock) begin
      if (!nrst) begin
         stall_done_q <= 1'b0;
         pwr_q <= '0;
         pend_q <= '0;
      end else begin
         stall_done_q <= stall;
         pwr_q <= pred_wr;
         for (int k = 0; k < NU; k++)
            pend_q[k*LN +: LN] <= (pend_q[k*LN +: LN] >> 1) |
                                  (fire ? new_wb[k*LN +: LN] : '0);
      end
   end

   // Dispatch outputs
   always_ff @(posedge clock) begin
      if (!nrst) begin
         unit_valid_q <= '0; unit_insn_q <= '0; unit_exec_q <= '0;
         imm0_valid_q <= 1'b0; imm0_q <= '0; imm0_unit_q <= '0;
         imm1_valid_q <= 1'b0; imm1_q <= '0; imm1_unit_q <= '0;
         wide_v_q <= 1'b0; wide_q <= '0; wb_exc_q <= 1'b0;
      end else begin
         unit_valid_q <= fire ? u_v_d : '0;
         imm0_valid_q <= fire && i0_v;
         imm1_valid_q <= fire && i1_v;
         wide_v_q <= fire && wide_v_d;
         wb_exc_q <= fire && wb_conf;
         if (fire) begin
            unit_insn_q <= u_i_d;
            unit_exec_q <= u_x_d;
            imm0_q <= i0_d; imm0_unit_q <= i0_u;
            imm1_q <= i1_d; imm1_unit_q <= i1_u;
            wide_q <= wide_d;
         end
      end
   end

   // Register slave: read data is fetched in the address phase, so a read
   // straight after a write to the same register returns the old value
   always_ff @(posedge clock) begin
      if (!nrst) begin
         hreadyout_q <= 1'b1; hrdata_q <= '0; wr_pend_q <= 1'b0; wa_q <= '0;
      end else begin
         wr_pend_q <= hsel && hready && htrans[1] && hwrite;
         if (hsel && hready && htrans[1]) begin
            wa_q <= haddr[7:0];
            unique case (haddr[7:0])
               epd_pkg::A_CTRL:   hrdata_q <= {31'h0, ctrl_en_q};
               epd_pkg::A_STATUS: hrdata_q <= {25'h0, status_q};
               epd_pkg::A_PKTS:   hrdata_q <= pkts_q;
               epd_pkg::A_STALLS: hrdata_q <= stalls_q;
               default:           hrdata_q <= '0;
            endcase
         end
      end
   end

   // Status bits: write one clears, a new event in the same cycle wins
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_en_q <= epd_pkg::CTRL_RST; status_q <= '0;
         pkts_q <= '0; stalls_q <= '0;
      end else begin
         if (wr_pend_q && wa_q == epd_pkg::A_CTRL) ctrl_en_q <= hwdata[0];
         status_q <= (status_q & ~((wr_pend_q && wa_q == epd_pkg::A_STATUS)
                     ? hwdata[epd_pkg::ST_W-1:0] : '0))
                     | (fire ? err_d : '0);
         if (fire) pkts_q <= pkts_q + 32'h1;
         if (stall) stalls_q <= stalls_q + 32'h1;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = epd_pkg::HRESP_OKAY;
   assign fp_ready = fp_ready_q;
   assign unit_valid = unit_valid_q;
   assign unit_insn = unit_insn_q;
   assign unit_exec = unit_exec_q;
   assign imm0_valid = imm0_valid_q;
   assign imm0 = imm0_q;
   assign imm0_unit = imm0_unit_q;
   assign imm1_valid = imm1_valid_q;
   assign imm1 = imm1_q;
   assign imm1_unit = imm1_unit_q;
   assign wide_imm_valid = wide_v_q;
   assign wide_imm = wide_q;
   assign wb_exception = wb_exc_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   chk_group_end: assert property (fire |-> !fp_q[int'(last_idx)*W]
                     || int'(last_idx) == NSLOT - 1)
      else $error("group did not end on a clear parallel flag");
   chk_fp_release: assert property (fire && done_fp |=> fp_ready_q
                     && !have_q)
      else $error("fetch packet not released after last group");
   chk_cursor_step: assert property (fire && !done_fp |=> have_q
                     && cursor_q == $past(nxt_cur))
      else $error("next group does not follow on the next cycle");
   chk_stall_once: assert property (stall |=> !stall
                     && $stable(cursor_q))
      else $error("predicate stall not exactly one cycle");
   chk_ext_silent: assert property (fire && n_norm == 5'h0 |=>
                     unit_valid_q == '0)
      else $error("extension slot dispatched to a unit");
   chk_wb_raise: assert property (fire && wb_conf |=> wb_exc_q
                     && status_q[epd_pkg::ST_WB])
      else $error("writeback conflict not reported");
   chk_rsv_flag: assert property (fire && rsv_d |=>
                     status_q[epd_pkg::ST_RSVSEL])
      else $error("reserved selector not flagged");
   chk_movk_value: assert property (fire && movk_d && i0_v |=>
                     imm0_q == {$past(x0_d[PW-1:0]), $past(movk_emb_d)})
      else $error("move constant value wrongly formed");
   chk_wide_value: assert property (fire && wide_v_d |=>
                     wide_q[63:10] == {$past(x1_d[PW-1:0]),
                                       $past(x0_d[PW-1:0])})
      else $error("wide constant value wrongly formed");
   cov_split: cover property (fire && !done_fp);
   cov_stall: cover property (stall ##1 fire);
   cov_wide: cover property (fire && wide_v_d);
endmodule : epd_dispatch
`default_nettype wire

// >>> verilog/epd_pkg.sv
// Purpose: Shared constants for the execute packet dispatch stage
// Assumes: 32-bit instruction words, 16-word fetch packets
// Notes:   Instruction field layout below is the decoder's own encoding
package epd_pkg;
   localparam int SLOTS  = 16;
   localparam int WORD_W = 32;
   localparam int NUNIT  = 13;
   localparam int NPRED  = 6;
   localparam int LAT_N  = 4;
   // Instruction fields
   localparam int PBIT      = 0;
   localparam int SEL_LO    = 28;
   localparam int EMB_LO    = 18;
   localparam int VEC_BIT   = 17;
   localparam int PDEST_BIT = 16;
   localparam int USEX_BIT  = 15;
   localparam int SDATA_BIT = 14;
   localparam int LAT_LO    = 12;
   localparam int UNIT_LO   = 8;
   localparam int CLS_LO    = 5;
   localparam int PAY_W     = 27;
   localparam int XID_LO    = 27;
   // Extension slot identifiers
   localparam logic [6:0] COND0_ID  = 7'h1d;
   localparam logic [6:0] COND1_ID  = 7'h5d;
   localparam logic [4:0] CONST0_ID = 5'h1e;
   localparam logic [4:0] CONST1_ID = 5'h1f;
   // Functional units
   localparam logic [3:0] U_L1 = 4'h0, U_L2 = 4'h1, U_S1 = 4'h2;
   localparam logic [3:0] U_S2 = 4'h3, U_D1 = 4'h4, U_D2 = 4'h5;
   localparam logic [3:0] U_M1 = 4'h6, U_M2 = 4'h7, U_N1 = 4'h8;
   localparam logic [3:0] U_N2 = 4'h9, U_C  = 4'ha, U_P  = 4'hb;
   localparam logic [3:0] U_B  = 4'hc;
   // Instruction classes
   localparam logic [2:0] CLS_PLAIN  = 3'h0;
   localparam logic [2:0] CLS_BRANCH = 3'h1;
   localparam logic [2:0] CLS_MOVK   = 3'h2;
   localparam logic [2:0] CLS_MOVW   = 3'h3;
   localparam logic [2:0] CLS_STW    = 3'h4;
   localparam logic [2:0] CLS_CTLMOV = 3'h5;
   // Predicate selector codes
   localparam logic [3:0] SEL_UNCOND = 4'h0;
   localparam logic [3:0] SEL_RSV    = 4'h1;
   localparam logic [2:0] SEL_TOP    = 3'h7;
   // Registers
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_PKTS   = 8'h08;
   localparam logic [7:0] A_STALLS = 8'h0c;
   localparam logic       CTRL_RST = 1'h1;
   localparam int ST_UNIT = 0, ST_BRLAST = 1, ST_PDEST = 2, ST_EXTCNT = 3;
   localparam int ST_WB = 4, ST_RSVSEL = 5, ST_EXTUSE = 6, ST_W = 7;
   localparam logic       HRESP_OKAY = 1'h0;
endpackage : epd_pkg
